// *** fas_pkg.sv ***
package fas_pkg;
  // Array sizes and region limits, in bytes except DATA_PAGES, which counts pages
  localparam logic [15:0] SPACE_TOP = 16'hffff;
  localparam logic [15:0] PROG_BYTES = 16'hf800;
  localparam logic [15:0] USER_DOWNLOAD_MODE_BYTES = 16'he000;
  localparam logic [15:0] DATA_BYTES = 16'h1000;
  localparam logic [15:0] DATA_PAGES = 16'h0400;
  localparam logic [15:0] PROG_PAGE_BYTES = 16'h0040;
  localparam int PAGE_BYTES = 4;
  // Reset vectors
  localparam logic [15:0] BOOT_VEC = 16'he000;
  localparam logic [15:0] RESET_VEC = 16'h0000;
  // Command register codes
  localparam logic [7:0] CMD_READ = 8'h01;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_VERIFY = 8'h04;
  localparam logic [7:0] CMD_ERASE_PAGE = 8'h05;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h06;
  localparam logic [7:0] CMD_READ_BYTE = 8'h81;
  localparam logic [7:0] CMD_WRITE_BYTE = 8'h82;
  localparam logic [7:0] CMD_RESET = 8'h00;
  localparam logic [7:0] VERIFY_OK = 8'h00;
  localparam logic [7:0] VERIFY_FAIL = 8'h01;
  localparam logic [7:0] ERASED = 8'hff;
  localparam logic [7:0] REG_RESET = 8'h00;
  // Parallel programming operations selected on port_three
  localparam logic [7:0] PP_PROGRAM = 8'h01;
  localparam logic [7:0] PP_READ = 8'h02;
  localparam logic [7:0] PP_CODE_ERASE = 8'h03;
  localparam logic [7:0] PP_SET_SEC = 8'h04;

  typedef enum logic [2:0] {
    FAS_SEL_CMD, FAS_SEL_DATA1, FAS_SEL_DATA2, FAS_SEL_DATA3,
    FAS_SEL_DATA4, FAS_SEL_ADRH, FAS_SEL_ADRL, FAS_SEL_NONE
  } fas_sel_e;

  typedef enum logic [1:0] {
    FAS_MODE_START, FAS_MODE_RUN, FAS_MODE_SERIAL, FAS_MODE_PARALLEL
  } fas_mode_e;

  typedef struct packed {
    logic wr;
    logic rd;
    fas_sel_e sel;
    logic [7:0] wdata;
  } fas_sfr_req_s;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } fas_dl_wr_s;

  typedef struct packed {
    logic lock;
    logic secure;
    logic serial_safe;
  } fas_sec_s;

  localparam fas_sec_s SEC_RESET = 3'b000;
endpackage

// *** fas_sweep.sv ***
`timescale 1ns/10ps
// Walks a run of addresses one per cycle, used for erases
module fas_sweep (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic start_in,
  input wire logic [15:0] base_in,
  input wire logic [15:0] len_in,
  output logic active_out,
  output logic [15:0] index_out,
  output logic done_out
);
  logic [15:0] left;

  // A start while active is dropped; callers gate on active_out
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      active_out <= 1'b0;
      index_out <= 16'h0000;
      left <= 16'h0000;
      done_out <= 1'b0;
    end else if (start_in && !active_out) begin
      active_out <= 1'b1;
      index_out <= base_in;
      left <= len_in - 16'h0001;
      done_out <= 1'b0;
    end else if (active_out) begin
      if (left == 16'h0000) begin
        active_out <= 1'b0;
        done_out <= 1'b1;
      end else begin
        index_out <= index_out + 16'h0001;
        left <= left - 16'h0001;
        done_out <= 1'b0;
      end
    end else begin
      done_out <= 1'b0;
    end
  end
endmodule

// *** fas_flash_access.sv ***
`timescale 1ns/10ps
module fas_flash_access (
  input wire logic clock_in,
  input wire logic sys_rst_in,
  input wire logic por_rst_in,
  input wire logic program_store_enable_pin_n_in,
  input wire logic parallel_strap_in,
  input wire logic user_download_mode_in,
  input wire logic core_ext_exec_in,
  input wire fas_pkg::fas_sfr_req_s sfr_req_in,
  input wire logic code_rd_req_in,
  input wire logic [15:0] code_rd_addr_in,
  input wire fas_pkg::fas_dl_wr_s dl_wr_in,
  input wire logic dl_code_erase_in,
  input wire logic dl_opt_wr_in,
  input wire fas_pkg::fas_sec_s dl_opt_sec_in,
  input wire logic dl_opt_boot_in,
  input wire logic [7:0] port_zero_in,
  input wire logic [7:0] port_one_in,
  input wire logic [7:0] port_two_in,
  input wire logic [7:0] port_three_in,
  input wire logic addr_latch_strobe_in,
  output logic [7:0] port_zero_out,
  output logic port_zero_oe_n_out,
  output logic [7:0] sfr_rdata_out,
  output logic code_rd_valid_out,
  output logic [7:0] code_rd_data_out,
  output logic code_rd_blocked_out,
  output logic nv_busy_out,
  output fas_pkg::fas_mode_e mode_out,
  output fas_pkg::fas_sec_s sec_out,
  output logic [15:0] boot_vector_out
);
  logic rst;
  logic boot_en;
  logic [7:0] page_address_high;
  logic [7:0] page_address_low;
  logic [7:0] cmd_rb;
  logic [3:0][7:0] page_buf;
  logic [7:0] data_mem [fas_pkg::DATA_BYTES];
  logic [7:0] prog_mem [fas_pkg::PROG_BYTES];
  logic strobe_q;
  logic busy;
  logic [15:0] sweep_idx;
  logic sweep_to_prog;
  logic next_sweep_prog;
  logic sweep_start;
  logic [15:0] sweep_base;
  logic [15:0] sweep_len;
  logic core_ok;
  logic cmd_go;
  logic user_download_mode;
  logic [7:0] cmd;
  logic [15:0] adr16;
  logic [9:0] pg;
  logic [11:0] bt;
  logic match;
  logic pp_fire;
  logic [15:0] pp_addr;
  logic pp_erase;
  logic dl_erase;
  logic prog_we;
  logic [15:0] prog_wa;
  logic [7:0] prog_wd;

  // Strap and mode state is cleared by either reset
  fas_pkg::fas_mode_e mode_q;
  assign rst = sys_rst_in | por_rst_in;
  assign mode_out = fas_pkg::fas_mode_e'(mode_q);

  // Mode chosen on the first edge after reset release, never at reset itself
  always_ff @(posedge clock_in or posedge rst) begin
    if (rst) begin
      mode_q <= fas_pkg::FAS_MODE_START;
    end else if (mode_q == fas_pkg::FAS_MODE_START) begin
      if (!program_store_enable_pin_n_in && !sec_out.serial_safe) begin
        mode_q <= fas_pkg::FAS_MODE_SERIAL;
      end else if (parallel_strap_in) begin
        mode_q <= fas_pkg::FAS_MODE_PARALLEL;
      end else begin
        mode_q <= fas_pkg::FAS_MODE_RUN;
      end
    end
  end

  // Core side decode; external code with secure set gets no commands or register writes
  always_comb begin
    user_download_mode = user_download_mode_in;
    cmd = sfr_req_in.wdata;
    adr16 = {page_address_high, page_address_low};
    pg = {page_address_high[1:0], page_address_low};
    bt = {page_address_high[3:0], page_address_low};
    core_ok = (mode_q == fas_pkg::FAS_MODE_RUN) && !busy
              && !(sec_out.secure && core_ext_exec_in);
    cmd_go = core_ok && sfr_req_in.wr && (sfr_req_in.sel == fas_pkg::FAS_SEL_CMD);
    match = 1'b1;
    for (int i = 0; i < fas_pkg::PAGE_BYTES; i++) begin
      if (data_mem[{pg, 2'(i)}] != page_buf[i]) begin
        match = 1'b0;
      end
    end
  end

  // Parallel strobe is a rising edge on the latch pin
  always_comb begin
    pp_fire = (mode_q == fas_pkg::FAS_MODE_PARALLEL) && addr_latch_strobe_in
              && !strobe_q && !busy;
    pp_addr = {port_two_in, port_one_in};
    pp_erase = pp_fire && (port_three_in == fas_pkg::PP_CODE_ERASE);
    dl_erase = (mode_q == fas_pkg::FAS_MODE_SERIAL) && dl_code_erase_in && !busy;
  end

  // Erase runs go through the sweep; one at a time
  always_comb begin
    sweep_start = 1'b0;
    sweep_base = 16'h0000;
    sweep_len = fas_pkg::PROG_BYTES;
    next_sweep_prog = 1'b1;
    if (pp_erase || dl_erase) begin
      sweep_start = 1'b1;
    end else if (cmd_go && !user_download_mode && cmd == fas_pkg::CMD_ERASE_ALL) begin
      sweep_start = 1'b1;
      sweep_len = fas_pkg::DATA_BYTES;
      next_sweep_prog = 1'b0;
    end else if (cmd_go && user_download_mode && cmd == fas_pkg::CMD_ERASE_ALL) begin
      sweep_start = 1'b1;
      sweep_len = fas_pkg::USER_DOWNLOAD_MODE_BYTES;
    end else if (cmd_go && user_download_mode && cmd == fas_pkg::CMD_ERASE_PAGE && adr16 < fas_pkg::USER_DOWNLOAD_MODE_BYTES) begin
      sweep_start = 1'b1;
      sweep_base = {adr16[15:6], 6'h00};
      sweep_len = fas_pkg::PROG_PAGE_BYTES;
    end
  end

  fas_sweep u_sweep (
    .clock_in(clock_in),
    .rst_in(rst),
    .start_in(sweep_start),
    .base_in(sweep_base),
    .len_in(sweep_len),
    .active_out(busy),
    .index_out(sweep_idx),
    .done_out()
  );
  assign nv_busy_out = busy;

  always_ff @(posedge clock_in or posedge rst) begin
    if (rst) begin
      sweep_to_prog <= 1'b0;
    end else if (sweep_start && !busy) begin
      sweep_to_prog <= next_sweep_prog;
    end
  end

  // Byte programming of the code array; each path checks its region
  always_comb begin
    prog_we = 1'b0;
    prog_wa = adr16;
    prog_wd = page_buf[0];
    if (cmd_go && user_download_mode && cmd == fas_pkg::CMD_WRITE_BYTE) begin
      prog_we = adr16 < fas_pkg::USER_DOWNLOAD_MODE_BYTES;
    end else if (pp_fire && port_three_in == fas_pkg::PP_PROGRAM) begin
      prog_wa = pp_addr;
      prog_wd = port_zero_in;
      prog_we = !sec_out.lock && !sec_out.secure && pp_addr < fas_pkg::PROG_BYTES;
    end else if (mode_q == fas_pkg::FAS_MODE_SERIAL && dl_wr_in.valid && !busy) begin
      prog_wa = dl_wr_in.addr;
      prog_wd = dl_wr_in.data;
      prog_we = dl_wr_in.addr < fas_pkg::PROG_BYTES;
    end
  end

  // Programming only clears bits, so an unerased target keeps stale zeros
  always_ff @(posedge clock_in) begin
    if (busy && sweep_to_prog) begin
      prog_mem[sweep_idx] <= fas_pkg::ERASED;
    end else if (prog_we) begin
      prog_mem[prog_wa] <= prog_mem[prog_wa] & prog_wd;
    end
  end

  // Data array writes and erases outside user download mode
  always_ff @(posedge clock_in) begin
    if (busy && !sweep_to_prog) begin
      data_mem[sweep_idx[11:0]] <= fas_pkg::ERASED;
    end else if (cmd_go && !user_download_mode) begin
      unique case (cmd)
        fas_pkg::CMD_WRITE: begin
          for (int i = 0; i < fas_pkg::PAGE_BYTES; i++) begin
            data_mem[{pg, 2'(i)}] <= data_mem[{pg, 2'(i)}] & page_buf[i];
          end
        end
        fas_pkg::CMD_WRITE_BYTE: data_mem[bt] <= data_mem[bt] & page_buf[0];
        fas_pkg::CMD_ERASE_PAGE: begin
          for (int i = 0; i < fas_pkg::PAGE_BYTES; i++) begin
            data_mem[{pg, 2'(i)}] <= fas_pkg::ERASED;
          end
        end
        default: ; // Reserved and read codes leave the array alone
      endcase
    end
  end

  // Buffer and address registers freeze while busy
  always_ff @(posedge clock_in or posedge rst) begin
    if (rst) begin
      page_buf <= '0;
      page_address_high <= fas_pkg::REG_RESET;
      page_address_low <= fas_pkg::REG_RESET;
    end else if (cmd_go && !user_download_mode && cmd == fas_pkg::CMD_READ) begin
      for (int i = 0; i < fas_pkg::PAGE_BYTES; i++) begin
        page_buf[i] <= data_mem[{pg, 2'(i)}];
      end
    end else if (cmd_go && !user_download_mode && cmd == fas_pkg::CMD_READ_BYTE) begin
      page_buf[0] <= data_mem[bt];
    end else if (core_ok && sfr_req_in.wr) begin
      unique case (sfr_req_in.sel)
        fas_pkg::FAS_SEL_DATA1: page_buf[0] <= sfr_req_in.wdata;
        fas_pkg::FAS_SEL_DATA2: page_buf[1] <= sfr_req_in.wdata;
        fas_pkg::FAS_SEL_DATA3: page_buf[2] <= sfr_req_in.wdata;
        fas_pkg::FAS_SEL_DATA4: page_buf[3] <= sfr_req_in.wdata;
        fas_pkg::FAS_SEL_ADRH: page_address_high <= sfr_req_in.wdata;
        fas_pkg::FAS_SEL_ADRL: page_address_low <= sfr_req_in.wdata;
        default: ;
      endcase
    end
  end

  // Command readback echoes the code, or the verify verdict
  always_ff @(posedge clock_in or posedge rst) begin
    if (rst) begin
      cmd_rb <= fas_pkg::CMD_RESET;
    end else if (cmd_go) begin
      if (!user_download_mode && cmd == fas_pkg::CMD_VERIFY) begin
        cmd_rb <= match ? fas_pkg::VERIFY_OK : fas_pkg::VERIFY_FAIL;
      end else begin
        cmd_rb <= cmd;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst) begin
    if (rst) begin
      sfr_rdata_out <= fas_pkg::REG_RESET;
    end else if (sfr_req_in.rd) begin
      unique case (sfr_req_in.sel)
        fas_pkg::FAS_SEL_CMD: sfr_rdata_out <= cmd_rb;
        fas_pkg::FAS_SEL_DATA1: sfr_rdata_out <= page_buf[0];
        fas_pkg::FAS_SEL_DATA2: sfr_rdata_out <= page_buf[1];
        fas_pkg::FAS_SEL_DATA3: sfr_rdata_out <= page_buf[2];
        fas_pkg::FAS_SEL_DATA4: sfr_rdata_out <= page_buf[3];
        fas_pkg::FAS_SEL_ADRH: sfr_rdata_out <= page_address_high;
        fas_pkg::FAS_SEL_ADRL: sfr_rdata_out <= page_address_low;
        default: sfr_rdata_out <= fas_pkg::REG_RESET;
      endcase
    end
  end

  // Security and boot options model nonvolatile cells: power-on or parallel erase clears security, serial erase keeps serial_safe, only power-on clears boot
  always_ff @(posedge clock_in or posedge por_rst_in) begin
    if (por_rst_in) begin
      sec_out <= fas_pkg::SEC_RESET;
      boot_en <= 1'b0;
    end else if (pp_erase) begin
      sec_out <= fas_pkg::SEC_RESET;
    end else if (dl_erase) begin
      sec_out.lock <= 1'b0;
      sec_out.secure <= 1'b0;
    end else if (pp_fire && port_three_in == fas_pkg::PP_SET_SEC) begin
      sec_out <= sec_out | fas_pkg::fas_sec_s'(port_zero_in[2:0]);
    end else if (mode_q == fas_pkg::FAS_MODE_SERIAL && dl_opt_wr_in) begin
      sec_out <= sec_out | dl_opt_sec_in;
      boot_en <= boot_en | dl_opt_boot_in;
    end
  end

  // Vector the core fetches from after reset
  always_ff @(posedge clock_in or posedge rst) begin
    if (rst) begin
      boot_vector_out <= fas_pkg::RESET_VEC;
    end else begin
      boot_vector_out <= boot_en ? fas_pkg::BOOT_VEC : fas_pkg::RESET_VEC;
    end
  end

  // Code reads; lock alone does not block them
  always_ff @(posedge clock_in or posedge rst) begin
    if (rst) begin
      code_rd_valid_out <= 1'b0;
      code_rd_data_out <= fas_pkg::ERASED;
      code_rd_blocked_out <= 1'b0;
    end else begin
      code_rd_valid_out <= code_rd_req_in;
      code_rd_blocked_out <= code_rd_req_in && sec_out.secure && core_ext_exec_in;
      if (code_rd_req_in && !(sec_out.secure && core_ext_exec_in)
          && code_rd_addr_in < fas_pkg::PROG_BYTES) begin
        code_rd_data_out <= prog_mem[code_rd_addr_in];
      end else begin
        code_rd_data_out <= fas_pkg::ERASED;
      end
    end
  end

  // Parallel read drives port_zero; secure keeps the pins released
  always_ff @(posedge clock_in or posedge rst) begin
    if (rst) begin
      strobe_q <= 1'b0;
      port_zero_out <= fas_pkg::ERASED;
      port_zero_oe_n_out <= 1'b1;
    end else begin
      strobe_q <= addr_latch_strobe_in;
      port_zero_oe_n_out <= !(mode_q == fas_pkg::FAS_MODE_PARALLEL
                              && port_three_in == fas_pkg::PP_READ && !sec_out.secure);
      if (pp_fire && port_three_in == fas_pkg::PP_READ && pp_addr < fas_pkg::PROG_BYTES) begin
        port_zero_out <= sec_out.secure ? fas_pkg::ERASED : prog_mem[pp_addr];
      end
    end
  end

  chk_dl_entry: assert property (@(posedge clock_in) disable iff (rst)
    mode_q == fas_pkg::FAS_MODE_START && !program_store_enable_pin_n_in && !sec_out.serial_safe
    |=> mode_q == fas_pkg::FAS_MODE_SERIAL ##1 mode_q == fas_pkg::FAS_MODE_SERIAL)
    else $error("download entry missed");
  chk_safe_no_dl: assert property (@(posedge clock_in) disable iff (rst)
    mode_q == fas_pkg::FAS_MODE_START && sec_out.serial_safe |=> mode_q != fas_pkg::FAS_MODE_SERIAL)
    else $error("serial-safe ignored");
  chk_ro_normal: assert property (@(posedge clock_in) disable iff (rst)
    mode_q == fas_pkg::FAS_MODE_RUN && !user_download_mode |-> !prog_we && !(sweep_start && next_sweep_prog))
    else $error("program write outside user download");
  chk_top_region: assert property (@(posedge clock_in) disable iff (rst)
    mode_q == fas_pkg::FAS_MODE_RUN && prog_we |-> prog_wa < fas_pkg::USER_DOWNLOAD_MODE_BYTES)
    else $error("core wrote boot region");
  chk_lock_pp: assert property (@(posedge clock_in) disable iff (rst)
    pp_fire && port_three_in == fas_pkg::PP_PROGRAM && sec_out.lock |-> !prog_we)
    else $error("locked parallel program accepted");
  chk_secure_read: assert property (@(posedge clock_in) disable iff (rst)
    code_rd_req_in && sec_out.secure && core_ext_exec_in
    |=> code_rd_valid_out && code_rd_blocked_out && code_rd_data_out == fas_pkg::ERASED)
    else $error("secure code read leaked");
  chk_erase_clear: assert property (@(posedge clock_in) disable iff (rst)
    pp_erase || dl_erase |=> !sec_out.lock && !sec_out.secure ##1 busy)
    else $error("code erase left lock");
  chk_safe_kept: assert property (@(posedge clock_in) disable iff (rst)
    dl_erase && sec_out.serial_safe |=> sec_out.serial_safe)
    else $error("serial erase cleared serial-safe");
  chk_busy_hold: assert property (@(posedge clock_in) disable iff (rst)
    busy && $stable(busy) |=> $stable(page_address_low) && $stable(page_address_high) && $stable(page_buf))
    else $error("registers moved while busy");
  chk_verify_rb: assert property (@(posedge clock_in) disable iff (rst)
    cmd_go && !user_download_mode && cmd == fas_pkg::CMD_VERIFY && !match |=> cmd_rb == fas_pkg::VERIFY_FAIL)
    else $error("verify mismatch reads zero");
  cov_serial: cover property (@(posedge clock_in) disable iff (rst) mode_q == fas_pkg::FAS_MODE_SERIAL);
  cov_user_download_mode_erase: cover property (@(posedge clock_in) disable iff (rst) sweep_start && user_download_mode && cmd_go);
  cov_verify_ok: cover property (@(posedge clock_in) disable iff (rst) cmd_go && cmd == fas_pkg::CMD_VERIFY && match);
  cov_pp_read: cover property (@(posedge clock_in) disable iff (rst) !port_zero_oe_n_out && pp_fire);
endmodule

// *** fas_prog_model.sv ***
`timescale 1ns/10ps
// Download host and parallel programmer facing the block
module fas_prog_model (
  input wire logic clock_in,
  input wire logic [7:0] dev_p0_in,
  input wire logic dev_p0_oe_n_in,
  output fas_pkg::fas_dl_wr_s dl_wr_out,
  output logic dl_code_erase_out,
  output logic dl_opt_wr_out,
  output fas_pkg::fas_sec_s dl_opt_sec_out,
  output logic dl_opt_boot_out,
  output logic [7:0] port_zero_out,
  output logic [7:0] port_one_out,
  output logic [7:0] port_two_out,
  output logic [7:0] port_three_out,
  output logic strobe_out
);
  logic [7:0] drv;
  logic drv_en;
  // Shared bus: released lines show the inverse of the last value, not a stale copy
  assign port_zero_out = !dev_p0_oe_n_in ? dev_p0_in : (drv_en ? drv : ~drv);
  // Idle levels
  initial begin
    dl_wr_out = '0;
    dl_code_erase_out = 1'b0;
    dl_opt_wr_out = 1'b0;
    dl_opt_sec_out = '0;
    dl_opt_boot_out = 1'b0;
    port_one_out = 8'h00;
    port_two_out = 8'h00;
    port_three_out = 8'h00;
    strobe_out = 1'b0;
    drv = 8'h00;
    drv_en = 1'b0;
  end
  // One-cycle option write from the download host
  task automatic opt(input fas_pkg::fas_sec_s s, input logic boot);
    @(posedge clock_in);
    dl_opt_wr_out <= 1'b1;
    dl_opt_sec_out <= s;
    dl_opt_boot_out <= boot;
    @(posedge clock_in);
    dl_opt_wr_out <= 1'b0;
  endtask
  // One-cycle code erase from the download host
  task automatic erase();
    @(posedge clock_in);
    dl_code_erase_out <= 1'b1;
    @(posedge clock_in);
    dl_code_erase_out <= 1'b0;
  endtask
  // One-cycle byte program from the download host
  task automatic dl_byte(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock_in);
    dl_wr_out <= '{1'b1, a, d};
    @(posedge clock_in);
    dl_wr_out <= '0;
  endtask
  // Bus set up a cycle ahead of the strobe and held until the answer is taken
  task automatic par(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock_in);
    port_three_out <= op;
    port_two_out <= a[15:8];
    port_one_out <= a[7:0];
    drv <= d;
    drv_en <= (op != fas_pkg::PP_READ);
    @(posedge clock_in);
    strobe_out <= 1'b1;
    repeat (3) @(posedge clock_in);
    q = port_zero_out;
    strobe_out <= 1'b0;
  endtask
endmodule

// *** fas_flash_access_tb_top.sv ***
`timescale 1ns/10ps
`define CHK(got, exp) begin \
  samples_checked++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module fas_flash_access_tb_top;
  logic clock_in = 1'b0;
  logic sys_rst = 1'b1, por_rst = 1'b1, pse_n = 1'b1, strap = 1'b0, user_download_mode = 1'b0, ext = 1'b0;
  logic code_req = 1'b0, strobe, p0_oe_n, code_valid, code_blk, nv_busy, dl_erase, dl_opt_wr, dl_boot;
  logic [15:0] code_addr = 16'h0000, boot_vec;
  logic [7:0] p0_to_dev, p0_dev, p1, p2, p3, sfr_rdata, code_data, q;
  fas_pkg::fas_sfr_req_s sfr_req = '0;
  fas_pkg::fas_dl_wr_s dl_wr;
  fas_pkg::fas_sec_s dl_sec, sec;
  fas_pkg::fas_mode_e mode;
  int n_fail = 0, samples_checked = 0;
  // 40 MHz clock
  always #12.5 clock_in = ~clock_in;
  fas_flash_access i_fas_flash_access (.clock_in(clock_in), .sys_rst_in(sys_rst), .por_rst_in(por_rst),
    .program_store_enable_pin_n_in(pse_n), .parallel_strap_in(strap), .user_download_mode_in(user_download_mode),
    .core_ext_exec_in(ext), .sfr_req_in(sfr_req), .code_rd_req_in(code_req), .code_rd_addr_in(code_addr),
    .dl_wr_in(dl_wr), .dl_code_erase_in(dl_erase), .dl_opt_wr_in(dl_opt_wr), .dl_opt_sec_in(dl_sec),
    .dl_opt_boot_in(dl_boot), .port_zero_in(p0_to_dev), .port_one_in(p1), .port_two_in(p2),
    .port_three_in(p3), .addr_latch_strobe_in(strobe), .port_zero_out(p0_dev), .port_zero_oe_n_out(p0_oe_n),
    .sfr_rdata_out(sfr_rdata), .code_rd_valid_out(code_valid), .code_rd_data_out(code_data),
    .code_rd_blocked_out(code_blk), .nv_busy_out(nv_busy), .mode_out(mode), .sec_out(sec),
    .boot_vector_out(boot_vec));
  fas_prog_model i_fas_prog_model (.clock_in(clock_in), .dev_p0_in(p0_dev), .dev_p0_oe_n_in(p0_oe_n),
    .dl_wr_out(dl_wr), .dl_code_erase_out(dl_erase), .dl_opt_wr_out(dl_opt_wr), .dl_opt_sec_out(dl_sec),
    .dl_opt_boot_out(dl_boot), .port_zero_out(p0_to_dev), .port_one_out(p1), .port_two_out(p2),
    .port_three_out(p3), .strobe_out(strobe));
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Reset held 8 cycles; straps sampled at release
  task automatic do_reset(input logic por, input logic pse, input logic par);
    @(posedge clock_in);
    pse_n <= pse;
    strap <= par;
    sys_rst <= 1'b1;
    por_rst <= por;
    repeat (8) @(posedge clock_in);
    sys_rst <= 1'b0;
    por_rst <= 1'b0;
    repeat (3) @(negedge clock_in);
  endtask
  // Register write, one-cycle pulse
  task automatic sfr_wr(input fas_pkg::fas_sel_e s, input logic [7:0] d);
    @(posedge clock_in);
    sfr_req <= '{1'b1, 1'b0, s, d};
    @(posedge clock_in);
    sfr_req <= '0;
  endtask
  // Register read, data one cycle after the pulse
  task automatic sfr_rd(input fas_pkg::fas_sel_e s, output logic [7:0] d);
    @(posedge clock_in);
    sfr_req <= '{1'b0, 1'b1, s, 8'h00};
    @(posedge clock_in);
    sfr_req <= '0;
    @(negedge clock_in);
    d = sfr_rdata;
  endtask
  task automatic cmd_rd(input logic [7:0] c, output logic [7:0] d);
    sfr_wr(fas_pkg::FAS_SEL_CMD, c);
    sfr_rd(fas_pkg::FAS_SEL_CMD, d);
  endtask
  task automatic set_adr(input logic [15:0] a);
    sfr_wr(fas_pkg::FAS_SEL_ADRH, a[15:8]);
    sfr_wr(fas_pkg::FAS_SEL_ADRL, a[7:0]);
  endtask
  // Code fetch; answer pulse looked at in its own cycle
  task automatic code_rd(input logic [15:0] a, input logic [7:0] exp, input logic blk);
    @(posedge clock_in);
    code_req <= 1'b1;
    code_addr <= a;
    @(posedge clock_in);
    code_req <= 1'b0;
    @(negedge clock_in);
    `CHK({code_valid, code_blk, code_data}, {1'b1, blk, exp});
  endtask
  // Bounded wait for an erase sweep
  task automatic wait_idle(input int lim);
    int n = 0;
    repeat (2) @(posedge clock_in);
    while (nv_busy !== 1'b0 && n < lim) begin
      @(posedge clock_in);
      n++;
    end
    @(negedge clock_in);
    `CHK(nv_busy, 1'b0);
  endtask
  // Watchdog beyond the longest expected run
  initial begin
    repeat (95000) @(posedge clock_in);
    n_fail++;
    stop_test();
  end
  // Main sequence
  initial begin
    do_reset(1'b1, 1'b0, 1'b0);
    `CHK(mode, fas_pkg::FAS_MODE_SERIAL);
    i_fas_prog_model.opt(3'b111, 1'b0);
    @(negedge clock_in);
    `CHK(sec, 3'b111);
    i_fas_prog_model.erase();
    wait_idle(64000);
    `CHK(sec, 3'b001);
    i_fas_prog_model.dl_byte(16'he100, 8'h3c);
    i_fas_prog_model.opt(3'b000, 1'b1);
    do_reset(1'b0, 1'b1, 1'b1);
    `CHK(mode, fas_pkg::FAS_MODE_PARALLEL);
    i_fas_prog_model.par(fas_pkg::PP_SET_SEC, 16'h0000, 8'h04, q);
    `CHK(sec, 3'b101);
    i_fas_prog_model.par(fas_pkg::PP_PROGRAM, 16'h0100, 8'h00, q);
    i_fas_prog_model.par(fas_pkg::PP_READ, 16'h0100, 8'h00, q);
    `CHK({p0_oe_n, q}, {1'b0, 8'hff});
    i_fas_prog_model.par(fas_pkg::PP_SET_SEC, 16'h0000, 8'h02, q);
    i_fas_prog_model.par(fas_pkg::PP_READ, 16'h0100, 8'h00, q);
    `CHK(p0_oe_n, 1'b1);
    do_reset(1'b0, 1'b0, 1'b0);
    `CHK({mode, boot_vec}, {fas_pkg::FAS_MODE_RUN, fas_pkg::BOOT_VEC});
    @(posedge clock_in) ext <= 1'b1;
    code_rd(16'h0100, 8'hff, 1'b1);
    sfr_wr(fas_pkg::FAS_SEL_CMD, 8'h03);
    ext <= 1'b0;
    sfr_rd(fas_pkg::FAS_SEL_CMD, q);
    `CHK(q, fas_pkg::REG_RESET);
    set_adr(16'h03ff);
    sfr_wr(fas_pkg::FAS_SEL_CMD, fas_pkg::CMD_ERASE_PAGE);
    for (int i = 0; i < 4; i++) sfr_wr(fas_pkg::fas_sel_e'(3'(i + 1)), 8'h10 + 8'(i));
    sfr_wr(fas_pkg::FAS_SEL_CMD, fas_pkg::CMD_WRITE);
    for (int i = 0; i < 4; i++) sfr_wr(fas_pkg::fas_sel_e'(3'(i + 1)), 8'h00);
    sfr_wr(fas_pkg::FAS_SEL_CMD, fas_pkg::CMD_READ);
    for (int i = 0; i < 4; i++) begin
      sfr_rd(fas_pkg::fas_sel_e'(3'(i + 1)), q);
      `CHK(q, 8'h10 + 8'(i));
    end
    cmd_rd(fas_pkg::CMD_VERIFY, q);
    `CHK(q, fas_pkg::VERIFY_OK);
    sfr_wr(fas_pkg::FAS_SEL_DATA1, 8'h77);
    cmd_rd(fas_pkg::CMD_VERIFY, q);
    `CHK(q, fas_pkg::VERIFY_FAIL);
    set_adr(16'h0ffe);
    sfr_wr(fas_pkg::FAS_SEL_CMD, fas_pkg::CMD_READ_BYTE);
    cmd_rd(8'h03, q);
    `CHK(q, 8'h03);
    sfr_rd(fas_pkg::FAS_SEL_DATA1, q);
    `CHK(q, 8'h12);
    sfr_wr(fas_pkg::FAS_SEL_CMD, fas_pkg::CMD_ERASE_ALL);
    wait_idle(5000);
    sfr_wr(fas_pkg::FAS_SEL_CMD, fas_pkg::CMD_READ_BYTE);
    sfr_rd(fas_pkg::FAS_SEL_DATA1, q);
    `CHK(q, fas_pkg::ERASED);
    @(posedge clock_in) user_download_mode <= 1'b1;
    set_adr(16'h0100);
    sfr_wr(fas_pkg::FAS_SEL_DATA1, 8'h5a);
    sfr_wr(fas_pkg::FAS_SEL_CMD, fas_pkg::CMD_WRITE_BYTE);
    code_rd(16'h0100, 8'h5a, 1'b0);
    set_adr(16'he010);
    sfr_wr(fas_pkg::FAS_SEL_CMD, fas_pkg::CMD_WRITE_BYTE);
    code_rd(16'he010, 8'hff, 1'b0);
    set_adr(16'h0120);
    sfr_wr(fas_pkg::FAS_SEL_CMD, fas_pkg::CMD_ERASE_PAGE);
    wait_idle(100);
    code_rd(16'h0100, 8'hff, 1'b0);
    @(posedge clock_in) user_download_mode <= 1'b0;
    set_adr(16'h0200);
    sfr_wr(fas_pkg::FAS_SEL_CMD, fas_pkg::CMD_WRITE_BYTE);
    code_rd(16'h0200, 8'hff, 1'b0);
    code_rd(16'hf800, 8'hff, 1'b0);
    code_rd(16'he100, 8'h3c, 1'b0);
    stop_test();
  end
endmodule
